/* File: rtl/sssc_params.svh */
// constants for the scan sequencer control block
`ifndef SSSC_PARAMS_SVH
`define SSSC_PARAMS_SVH
`define SSSC_NCH 16
`define SSSC_CHW 4
`define SSSC_RW 16
`define SSSC_NCFG 4
`define SSSC_CFGW 2
`define SSSC_SWITCH_CYC 4'h4
`define SSSC_SW_ZERO 4'h0
`define SSSC_CH_FIRST 4'h0
`define SSSC_MASK_ZERO 16'h0000
`define SSSC_RES_ZERO 16'h0000
`define SSSC_PWR_LOW 2'h0
`define SSSC_PWR_SLOW 2'h1
`define SSSC_PWR_MID 2'h2
`define SSSC_PWR_HIGH 2'h3
`define SSSC_PWR_FAST_DIV 4'h2
`define SSSC_PWR_MID_DIV 4'h8
`endif

/* File: rtl/sssc_pkg.sv */
// types for the scan sequencer control block
`default_nettype none
package sssc_pkg;
  typedef enum {SSSC_OFF, SSSC_IDLE, SSSC_CONV, SSSC_SWITCH} sssc_state_t;
  typedef logic [15:0] sssc_word_t;
endpackage
`default_nettype wire

/* File: rtl/sssc_res_if.sv */
// write port carrying one channel result into the result store
`timescale 1ns/1ps
`default_nettype none
`include "sssc_params.svh"
interface sssc_res_if;
  logic we; // write strobe
  logic [`SSSC_CHW-1:0] waddr; // channel index
  logic [`SSSC_RW-1:0] wdata; // signed result
  logic [`SSSC_CHW-1:0] raddr; // read index
  logic [`SSSC_RW-1:0] rdata; // registered read data
  modport ctl (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface
`default_nettype wire

/* File: rtl/sssc_res_mem.sv */
// per-channel result store with registered read
`timescale 1ns/1ps
`default_nettype none
`include "sssc_params.svh"
module sssc_res_mem
  import sssc_pkg::*;
(
  input wire logic clk,
  sssc_res_if.mem port
);
  // one signed word per channel, index 0 first
  logic [`SSSC_RW-1:0] store [0:`SSSC_NCH-1];
  // write and registered read; contents need no reset, results are overwritten by scans
  always_ff @(posedge clk) begin
    if (port.we) begin
      store[port.waddr] <= port.wdata;
    end
    port.rdata <= store[port.raddr];
  end
endmodule
`default_nettype wire

/* File: rtl/sssc_top.sv */
// scan sequencer control around a multi-channel successive-approximation converter
// Behaviour
// - stop request lets current conversion finish first
// - full stop halts and selects lowest power
// - stop finishes scan, completion flag/event shows
// - config switch disables then re-enables converter, filter
// - restart of one resumes scanning after switch
// - free-running repeats; one-pass gives one scan
// - runtime mode override; config switch restores mode
// - one-pass trigger edge starts exactly one scan
// - free-running trigger level repeats scans while high
// - scan event interrupt needs local, global enable
// - pending scan event stays until software clears
// - mask write sets/clears mask, clears other flags
// - channel enable mask selects scanned channels
// - completion status nonzero after scan, zero during a scan started from idle
// - reading completion status clears it
// - one result register per channel from zero
// - results are signed 16-bit values
// - low/high limits and per-channel limit mask
// - per-channel saturation mask gates saturation events
// - startup powers with level from clock rate
// - level fall completes started scan, then stops
// - register and trigger starts both stay active
`timescale 1ns/1ps
`default_nettype none
`include "sssc_params.svh"
module sssc_top
  import sssc_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic POWER_UP, // pulse: initialise and power
  input wire logic FULL_STOP, // pulse: halt, lowest power
  input wire logic BEGIN_SCANNING, // pulse: begin_scanning_command
  input wire logic HALT_SCANNING, // pulse: halt_scanning_command
  input wire logic SET_MODE, // pulse: take MODE_IN as run-time mode
  input wire logic MODE_IN, // 1 free-running, 0 one-pass
  input wire logic CONFIG_SWITCH, // pulse: config_switch_command
  input wire logic [`SSSC_CFGW-1:0] CONFIG_SEL, // configuration number
  input wire logic CONFIG_RESTART, // restart after switch
  input wire logic [`SSSC_NCFG-1:0] CONFIG_MODE, // stored mode per config
  input wire logic [`SSSC_NCFG-1:0] CONFIG_FILTER, // filter used per config
  input wire logic [3:0] CLK_DIV, // converter clock divider, sets power level
  input wire logic TRIG_ENABLE, // hardware trigger in use
  input wire logic SCAN_TRIGGER, // asynchronous hardware trigger pin
  input wire logic IRQ_ENABLE, // local interrupt enable
  input wire logic GLOBAL_IRQ_ENABLE, // processor global enable
  input wire logic CLEAR_INTERRUPT, // pulse: clear pending scan event
  input wire logic MASK_WRITE, // pulse: write scan event mask
  input wire logic MASK_VALUE, // 1 set mask, 0 clear
  input wire logic STATUS_READ, // pulse: read completion status
  input wire logic [`SSSC_NCH-1:0] CHAN_MASK, // channel enables
  input wire logic [`SSSC_NCH-1:0] LIMIT_MASK, // channels that may flag limits
  input wire logic [`SSSC_NCH-1:0] SAT_MASK, // channels that may flag saturation
  input wire logic signed [`SSSC_RW-1:0] LOW_LIMIT, // low compare limit
  input wire logic signed [`SSSC_RW-1:0] HIGH_LIMIT, // high compare limit
  input wire logic CONV_DONE, // converter finished one channel
  input wire logic signed [`SSSC_RW-1:0] CONV_DATA, // converter result
  input wire logic CONV_SAT, // converter saturated on this sample
  input wire logic [`SSSC_CHW-1:0] RESULT_SEL, // channel index to read
  output logic CONV_START, // pulse: start channel conversion
  output logic [`SSSC_CHW-1:0] CONV_CHAN, // channel being converted
  output logic CONV_ENABLE, // converter powered and enabled
  output logic FILTER_ENABLE, // filter enabled
  output logic [1:0] POWER_LEVEL, // converter power level
  output logic MODE_FREE, // effective mode
  output logic BUSY, // scan in progress
  output logic COMPLETE_STATUS, // completion status as last read
  output logic SCAN_IRQ, // interrupt to processor
  output logic SCAN_PENDING, // pending scan event flag
  output logic LIMIT_FLAG, // sticky limit flag
  output logic SAT_FLAG, // sticky saturation flag
  output logic signed [`SSSC_RW-1:0] RESULT_DATA // selected result
);
  // whole state in one struct
  typedef struct packed {
    sssc_state_t st;
    logic [1:0] trig_sync; // two-stage synchroniser
    logic trig_prev; // previous synced level for edge
    logic free_mode; // effective mode
    logic run; // free-running start latched
    logic one_req; // one-pass scan requested
    logic halt_req; // stop after current scan
    logic waiting; // conversion outstanding
    logic [`SSSC_CHW-1:0] chan;
    logic [3:0] sw_cnt; // switch dwell
    logic sw_restart;
    logic [`SSSC_CFGW-1:0] cfg;
    logic done_flag; // completion status, read-to-clear
    logic eos_pend;
    logic eos_mask;
    logic conv_start;
    logic conv_en;
    logic filt_en;
    logic [1:0] pwr;
    logic busy;
    logic status_out;
    logic irq;
    logic limit_flag;
    logic sat_flag;
  } sssc_regs_t;

  sssc_regs_t r; // registered state
  sssc_regs_t n; // next state
  sssc_res_if res(); // result store port

  sssc_res_mem u_mem (.clk(CLOCK), .port(res.mem));

  logic trig_lvl; // synchronised trigger
  logic trig_edge; // rising edge
  logic [`SSSC_CHW-1:0] next_chan; // next enabled channel after current
  logic last_chan; // no enabled channel above current
  logic [`SSSC_CHW-1:0] first_chan; // lowest enabled channel
  logic any_chan; // some channel enabled
  logic scan_end; // last channel result arriving
  logic limit_hit; // out-of-range masked result
  logic want_scan; // some source asks for another scan

  assign trig_lvl = r.trig_sync[1];
  assign trig_edge = trig_lvl & ~r.trig_prev;

  // search for the first and the next enabled channel; the mask may change
  // at any time, which reshapes the scan and its rate
  always_comb begin
    first_chan = `SSSC_CH_FIRST;
    any_chan = 1'b0;
    next_chan = r.chan;
    last_chan = 1'b1;
    for (int i = `SSSC_NCH - 1; i >= 0; i--) begin
      if (CHAN_MASK[i]) begin
        first_chan = i[`SSSC_CHW-1:0];
        any_chan = 1'b1;
        if (i > int'(r.chan)) begin
          next_chan = i[`SSSC_CHW-1:0];
          last_chan = 1'b0;
        end
      end
    end
  end

  // result accepted while waiting; it lands at the current channel index
  assign scan_end = r.waiting & CONV_DONE & last_chan;
  assign limit_hit = LIMIT_MASK[r.chan] &
    ((CONV_DATA < LOW_LIMIT) | (CONV_DATA > HIGH_LIMIT));
  // free-running continues on run or held level; one-pass needs a request
  assign want_scan = r.free_mode ? ((r.run & ~r.halt_req) | (TRIG_ENABLE & trig_lvl))
    : r.one_req;

  // result store: one word per channel, signed two's complement
  always_comb begin
    res.we = r.waiting & CONV_DONE;
    res.waddr = r.chan;
    res.wdata = CONV_DATA;
    res.raddr = RESULT_SEL;
  end

  // next-state logic
  always_comb begin
    n = r;
    n.conv_start = 1'b0;
    n.trig_sync = {r.trig_sync[0], SCAN_TRIGGER};
    n.trig_prev = trig_lvl;
    // run-time mode override
    if (SET_MODE) begin
      n.free_mode = MODE_IN;
    end
    // register start and trigger edge both count
    if (BEGIN_SCANNING) begin
      // only a free-running start latches; a one-pass start must not resurface later
      n.run = r.free_mode;
      n.one_req = 1'b1;
      n.halt_req = 1'b0;
    end
    if (TRIG_ENABLE & trig_edge & ~r.free_mode) begin
      n.one_req = 1'b1;
    end
    // stop request only takes effect at the end of the scan
    if (HALT_SCANNING) begin
      n.run = 1'b0;
      n.halt_req = r.busy;
      n.one_req = 1'b0;
    end
    // sticky sample flags
    if (res.we & limit_hit) begin
      n.limit_flag = 1'b1;
    end
    if (res.we & CONV_SAT & SAT_MASK[r.chan]) begin
      n.sat_flag = 1'b1;
    end
    // status read returns and clears; a new completion wins
    if (STATUS_READ) begin
      n.status_out = r.done_flag;
      n.done_flag = 1'b0;
    end
    if (CLEAR_INTERRUPT) begin
      n.eos_pend = 1'b0;
    end
    if (MASK_WRITE) begin
      n.eos_mask = MASK_VALUE;
      n.eos_pend = 1'b0;
      n.limit_flag = 1'b0;
      n.sat_flag = 1'b0;
    end
    case (r.st)
      SSSC_OFF: begin
        n.busy = 1'b0;
        n.conv_en = 1'b0;
        n.filt_en = 1'b0;
        n.pwr = `SSSC_PWR_LOW;
        if (POWER_UP) begin
          n.st = SSSC_IDLE;
          n.conv_en = 1'b1;
          n.filt_en = CONFIG_FILTER[r.cfg];
          // faster converter clock (smaller divider) needs more bias
          n.pwr = (CLK_DIV <= `SSSC_PWR_FAST_DIV) ? `SSSC_PWR_HIGH :
            (CLK_DIV <= `SSSC_PWR_MID_DIV) ? `SSSC_PWR_MID : `SSSC_PWR_SLOW;
        end
      end
      SSSC_IDLE: begin
        n.busy = 1'b0;
        n.halt_req = 1'b0;
        if (want_scan & any_chan) begin
          n.st = SSSC_CONV;
          n.busy = 1'b1;
          n.one_req = 1'b0;
          n.chan = first_chan;
          n.conv_start = 1'b1;
          n.waiting = 1'b1;
          n.done_flag = 1'b0;
        end
      end
      SSSC_CONV: begin
        if (r.waiting & CONV_DONE) begin
          n.waiting = 1'b0;
          if (scan_end) begin
            n.done_flag = 1'b1;
            n.eos_pend = 1'b1;
            // back-to-back only while a source still asks; a fallen level ends here
            if (want_scan & ~r.halt_req & any_chan) begin
              n.chan = first_chan;
              n.conv_start = 1'b1;
              n.waiting = 1'b1;
              n.one_req = 1'b0;
            end else begin
              n.st = SSSC_IDLE;
              n.busy = 1'b0;
              n.halt_req = 1'b0;
            end
          end else begin
            n.chan = next_chan;
            n.conv_start = 1'b1;
            n.waiting = 1'b1;
          end
        end
      end
      SSSC_SWITCH: begin
        n.sw_cnt = r.sw_cnt - 4'h1;
        if (r.sw_cnt == `SSSC_SW_ZERO) begin
          n.conv_en = 1'b1;
          n.filt_en = CONFIG_FILTER[r.cfg];
          n.st = SSSC_IDLE;
          n.run = r.sw_restart;
          n.one_req = r.sw_restart;
        end
      end
      default: begin
        n.st = SSSC_OFF;
      end
    endcase
    // config switch: drop enables, dwell, reload mode
    if (CONFIG_SWITCH & (r.st != SSSC_OFF)) begin
      n.st = SSSC_SWITCH;
      n.cfg = CONFIG_SEL;
      n.free_mode = CONFIG_MODE[CONFIG_SEL];
      n.conv_en = 1'b0;
      n.filt_en = 1'b0;
      n.sw_cnt = `SSSC_SWITCH_CYC;
      n.sw_restart = CONFIG_RESTART;
      n.busy = 1'b0;
      n.waiting = 1'b0;
      n.run = 1'b0;
      n.one_req = 1'b0;
      n.halt_req = 1'b0;
    end
    // full stop cuts enables, power and requests at once; flags stay and a same-cycle start still pulses
    if (FULL_STOP) begin
      n.st = SSSC_OFF;
      n.conv_en = 1'b0;
      n.filt_en = 1'b0;
      n.pwr = `SSSC_PWR_LOW;
      n.busy = 1'b0;
      n.waiting = 1'b0;
      n.run = 1'b0;
      n.one_req = 1'b0;
      n.halt_req = 1'b0;
    end
    n.irq = n.eos_pend & n.eos_mask & IRQ_ENABLE & GLOBAL_IRQ_ENABLE;
  end

  // register the state; synchronous reset to constants
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      r <= '0;
      r.st <= SSSC_OFF;
    end else begin
      r <= n;
    end
  end

  // outputs straight from flip-flops
  always_comb begin
    CONV_START = r.conv_start;
    CONV_CHAN = r.chan;
    CONV_ENABLE = r.conv_en;
    FILTER_ENABLE = r.filt_en;
    POWER_LEVEL = r.pwr;
    MODE_FREE = r.free_mode;
    BUSY = r.busy;
    COMPLETE_STATUS = r.status_out;
    SCAN_IRQ = r.irq;
    SCAN_PENDING = r.eos_pend;
    LIMIT_FLAG = r.limit_flag;
    SAT_FLAG = r.sat_flag;
    RESULT_DATA = res.rdata;
  end
endmodule
`default_nettype wire

/* File: verif/sssc_conv_model.sv */
// behavioural converter answering each channel start after a short or long wait
`timescale 1ns/1ps
`default_nettype none
module sssc_conv_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic start, // begin one channel
  input wire logic [3:0] chan, // channel to convert
  input wire logic slow, // 1 stretches the wait
  output logic done, // one-cycle completion
  output logic signed [15:0] data, // result, valid with done only
  output logic sat // saturation, valid with done only
);
  logic busy;
  logic [2:0] cnt;
  logic [3:0] ch;
  // data and sat toggle outside done so a stale value never looks valid
  always_ff @(posedge clk) begin
    done <= 1'b0;
    data <= ~data;
    sat <= ~sat;
    if (rst) begin
      busy <= 1'b0;
      data <= 16'h0000;
      sat <= 1'b0;
    end else if (start) begin
      busy <= 1'b1;
      ch <= chan;
      cnt <= slow ? 3'h4 : 3'h0;
    end else if (busy && cnt != 3'h0) begin
      cnt <= cnt - 3'h1;
    end else if (busy) begin
      busy <= 1'b0;
      done <= 1'b1;
      data <= {4{ch}};
      sat <= ch[0];
    end
  end
endmodule
`default_nettype wire

/* File: verif/sssc_props.sv */
// concurrent checks on the scan sequencer control ports
`timescale 1ns/1ps
`default_nettype none
module sssc_props (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic POWER_UP,
  input wire logic FULL_STOP,
  input wire logic BEGIN_SCANNING,
  input wire logic HALT_SCANNING,
  input wire logic CONFIG_SWITCH,
  input wire logic [3:0] CLK_DIV,
  input wire logic IRQ_ENABLE,
  input wire logic GLOBAL_IRQ_ENABLE,
  input wire logic CLEAR_INTERRUPT,
  input wire logic MASK_WRITE,
  input wire logic [15:0] CHAN_MASK,
  input wire logic [15:0] LIMIT_MASK,
  input wire logic signed [15:0] LOW_LIMIT,
  input wire logic signed [15:0] HIGH_LIMIT,
  input wire logic CONV_DONE,
  input wire logic signed [15:0] CONV_DATA,
  input wire logic CONV_START,
  input wire logic [3:0] CONV_CHAN,
  input wire logic CONV_ENABLE,
  input wire logic [1:0] POWER_LEVEL,
  input wire logic BUSY,
  input wire logic SCAN_IRQ,
  input wire logic SCAN_PENDING,
  input wire logic LIMIT_FLAG
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RST);
  // interrupt output needs both enables
  a_irq_both_en:
    assert property (SCAN_IRQ |-> $past(IRQ_ENABLE && GLOBAL_IRQ_ENABLE))
    else $error("interrupt without both enables");
  // pending event leaves only through a clear or a mask write
  a_pending_sticky:
    assert property ($fell(SCAN_PENDING) |-> $past(CLEAR_INTERRUPT || MASK_WRITE))
    else $error("pending event dropped on its own");
  // mask write wipes the other flags
  a_mask_clears:
    assert property (MASK_WRITE && !CONV_DONE |=> !SCAN_PENDING && !LIMIT_FLAG)
    else $error("mask write left flags set");
  a_full_stop_low:
    assert property (FULL_STOP |=> !CONV_ENABLE && !BUSY && POWER_LEVEL == 2'h0)
    else $error("full stop did not halt at low power");
  // power level follows the divider: fast clock needs the most power
  a_power_by_clock:
    assert property ($rose(CONV_ENABLE) && $past(POWER_UP) |-> POWER_LEVEL ==
      ($past(CLK_DIV) <= 4'h2 ? 2'h3 : ($past(CLK_DIV) <= 4'h8 ? 2'h2 : 2'h1)))
    else $error("power level wrong for divider");
  // switching drops the converter for the dwell, then brings it back
  a_switch_dwell:
    assert property (CONFIG_SWITCH && CONV_ENABLE |=> !CONV_ENABLE [*4] ##[1:3] CONV_ENABLE)
    else $error("config switch dwell wrong");
  a_start_answers:
    assert property (BEGIN_SCANNING && CONV_ENABLE && !BUSY && |CHAN_MASK && !HALT_SCANNING
      && !FULL_STOP && !CONFIG_SWITCH |-> ##[1:2] CONV_START)
    else $error("start command not answered");
  a_limit_raise:
    assert property (CONV_DONE && LIMIT_MASK[CONV_CHAN] && !MASK_WRITE &&
      (CONV_DATA < LOW_LIMIT || CONV_DATA > HIGH_LIMIT) |-> ##[1:2] LIMIT_FLAG)
    else $error("limit flag missing");
endmodule
bind sssc_top sssc_props u_props (.*);
`default_nettype wire

/* File: verif/sssc_top_tb.sv */
// self-checking bench for the scan sequencer control
`timescale 1ns/1ps
`default_nettype none
module sssc_top_tb;
  logic CLOCK = 1'b0;
  logic RST = 1'b1;
  logic POWER_UP, FULL_STOP, BEGIN_SCANNING, HALT_SCANNING, SET_MODE, MODE_IN, CONFIG_SWITCH;
  logic CONFIG_RESTART, TRIG_ENABLE, SCAN_TRIGGER, IRQ_ENABLE, GLOBAL_IRQ_ENABLE;
  logic CLEAR_INTERRUPT, MASK_WRITE, MASK_VALUE, STATUS_READ, CONV_DONE, CONV_SAT, slow;
  logic [1:0] CONFIG_SEL, POWER_LEVEL;
  logic [3:0] CONFIG_MODE, CONFIG_FILTER, CLK_DIV, RESULT_SEL, CONV_CHAN;
  logic [15:0] CHAN_MASK, LIMIT_MASK, SAT_MASK;
  logic signed [15:0] LOW_LIMIT, HIGH_LIMIT, CONV_DATA, RESULT_DATA;
  logic CONV_START, CONV_ENABLE, FILTER_ENABLE, MODE_FREE, BUSY, COMPLETE_STATUS;
  logic SCAN_IRQ, SCAN_PENDING, LIMIT_FLAG, SAT_FLAG;
  int fail_count = 0;
  int n_tests = 0;
  int starts = 0;
  int s0;
  logic [31:0] r = 32'hE044; // lfsr state, fixed seed
  sssc_top DUT (.*);
  sssc_conv_model u_conv (.clk(CLOCK), .rst(RST), .start(CONV_START), .chan(CONV_CHAN),
    .slow(slow), .done(CONV_DONE), .data(CONV_DATA), .sat(CONV_SAT));
  always #2.5 CLOCK = ~CLOCK;
  // count channel starts; a start on a masked-off channel is wrong
  always @(posedge CLOCK) if (CONV_START) begin
    starts <= starts + 1;
    if (!CHAN_MASK[CONV_CHAN]) chk(16'h0, 16'h1, "disabled channel");
  end
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // expected power level for a divider
  function automatic logic [1:0] pl(input logic [3:0] d);
    return d <= 4'h2 ? 2'h3 : (d <= 4'h8 ? 2'h2 : 2'h1);
  endfunction
  function automatic logic [3:0] top_ch(input logic [15:0] m);
    top_ch = 4'h0;
    for (int k = 0; k < 16; k++) if (m[k]) top_ch = 4'(k);
  endfunction
  task automatic chk(input logic [15:0] g, input logic [15:0] e, input string m);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %0t %s got %h want %h", $time, m, g, e);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge CLOCK);
  endtask
  // bounded wait for the scan to end; polled off the clock edge
  task automatic idle;
    int k;
    k = 0;
    tick(8);
    @(negedge CLOCK);
    // blocking query: wait until every enabled channel is done
    while (BUSY !== 1'b0 && k < 4000) begin
      @(negedge CLOCK);
      k++;
    end
    chk(BUSY, 16'h0, "scan never ended");
  endtask
  task automatic clr;
    @(posedge CLOCK) CLEAR_INTERRUPT <= 1'b1;
    @(posedge CLOCK) CLEAR_INTERRUPT <= 1'b0;
    @(negedge CLOCK) chk(SCAN_PENDING, 16'h0, "pending not cleared");
  endtask
  task automatic rd_status(input logic e);
    @(posedge CLOCK) STATUS_READ <= 1'b1;
    @(posedge CLOCK) STATUS_READ <= 1'b0;
    @(negedge CLOCK) chk(COMPLETE_STATUS, e, "completion status");
  endtask
  task automatic pwr(input logic [3:0] d);
    @(posedge CLOCK) POWER_UP <= 1'b1;
    CLK_DIV <= d;
    @(posedge CLOCK) POWER_UP <= 1'b0;
    @(negedge CLOCK) chk({CONV_ENABLE, POWER_LEVEL}, {1'b1, pl(d)}, "power up");
  endtask
  task automatic set_mode(input logic v);
    @(posedge CLOCK) SET_MODE <= 1'b1;
    MODE_IN <= v;
    @(posedge CLOCK) SET_MODE <= 1'b0;
  endtask
  // one single pass from a register start or a trigger edge held high
  task automatic one_scan(input logic [15:0] m, input logic trig);
    r = nxt(r);
    @(posedge CLOCK) CHAN_MASK <= m;
    LIMIT_MASK <= r[15:0];
    SAT_MASK <= r[31:16];
    IRQ_ENABLE <= r[16];
    GLOBAL_IRQ_ENABLE <= r[17];
    slow <= r[20];
    MASK_WRITE <= 1'b1;
    MASK_VALUE <= r[18];
    @(posedge CLOCK) MASK_WRITE <= 1'b0;
    s0 = starts;
    if (trig) SCAN_TRIGGER <= 1'b1;
    else BEGIN_SCANNING <= 1'b1;
    @(posedge CLOCK) BEGIN_SCANNING <= 1'b0;
    idle;
    chk(16'(starts - s0), 16'($countones(m)), "scan length");
    chk(SCAN_PENDING, 16'h1, "scan end event");
    chk(SCAN_IRQ, r[16] & r[17] & r[18], "interrupt gating");
    chk(LIMIT_FLAG, |(m & LIMIT_MASK & 16'h0FF0), "limit flag");
    chk(SAT_FLAG, |(m & SAT_MASK & 16'hAAAA), "saturation flag");
    @(posedge CLOCK) SCAN_TRIGGER <= 1'b0;
    RESULT_SEL <= top_ch(m);
    rd_status(1'b1);
    rd_status(1'b0);
    chk(RESULT_DATA, {4{top_ch(m)}}, "channel result");
    clr;
    $display("single pass %h done", m);
  endtask
  // free-running run stopped by halt or by the trigger level falling
  task automatic free_run(input logic trig);
    int k;
    k = 0;
    s0 = starts;
    @(posedge CLOCK);
    if (trig) SCAN_TRIGGER <= 1'b1;
    else BEGIN_SCANNING <= 1'b1;
    @(posedge CLOCK) BEGIN_SCANNING <= 1'b0;
    while (starts - s0 <= $countones(CHAN_MASK) && k < 4000) begin
      @(negedge CLOCK);
      k++;
    end
    chk(16'(k < 4000), 16'h1, "free run stalled");
    @(posedge CLOCK) SCAN_TRIGGER <= 1'b0;
    HALT_SCANNING <= !trig;
    @(posedge CLOCK) HALT_SCANNING <= 1'b0;
    idle;
    chk(16'((starts - s0) % $countones(CHAN_MASK)), 16'h0, "partial scan");
    chk(MODE_FREE, 16'h1, "run-time mode");
    clr;
    $display("free run %0d done", trig);
  endtask
  task automatic cfg(input logic [1:0] s, input logic rs);
    @(posedge CLOCK) CONFIG_SEL <= s;
    CONFIG_RESTART <= rs;
    CONFIG_SWITCH <= 1'b1;
    @(posedge CLOCK) CONFIG_SWITCH <= 1'b0;
    tick(12);
    @(negedge CLOCK) chk(MODE_FREE, CONFIG_MODE[s], "restored mode");
    chk(FILTER_ENABLE, CONFIG_FILTER[s], "filter enable");
    chk(BUSY, rs, "restart");
    $display("config %0d done", s);
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    {POWER_UP, FULL_STOP, BEGIN_SCANNING, HALT_SCANNING, SET_MODE, MODE_IN, CONFIG_SWITCH,
      CONFIG_RESTART, TRIG_ENABLE, SCAN_TRIGGER, IRQ_ENABLE, GLOBAL_IRQ_ENABLE, CLEAR_INTERRUPT,
      MASK_WRITE, MASK_VALUE, STATUS_READ, slow, CONFIG_SEL, CLK_DIV, RESULT_SEL, CHAN_MASK,
      LIMIT_MASK, SAT_MASK} = '0;
    CONFIG_MODE = 4'h5;
    CONFIG_FILTER = 4'h1;
    LOW_LIMIT = 16'hC000;
    HIGH_LIMIT = 16'h4000;
    tick(20);
    RST <= 1'b0;
    r = nxt(r);
    pwr(r[3:0]);
    @(posedge CLOCK) TRIG_ENABLE <= 1'b1;
    set_mode(1'b0);
    for (int i = 0; i < 6; i++) begin
      r = nxt(r);
      one_scan(i == 0 ? 16'h8000 : (i == 1 ? 16'hFFFF : r[15:0] | 16'h0001), 1'(i));
    end
    set_mode(1'b1);
    free_run(1'b0);
    free_run(1'b1);
    set_mode(1'b0);
    cfg(2'h0, 1'b1);
    @(posedge CLOCK) HALT_SCANNING <= 1'b1;
    @(posedge CLOCK) HALT_SCANNING <= 1'b0;
    idle;
    clr;
    s0 = starts;
    cfg(2'h1, 1'b0);
    chk(16'(starts - s0), 16'h0, "idle after switch");
    @(posedge CLOCK) FULL_STOP <= 1'b1;
    @(posedge CLOCK) FULL_STOP <= 1'b0;
    @(negedge CLOCK) chk({CONV_ENABLE, POWER_LEVEL}, 16'h0, "full stop");
    pwr(4'h8);
    wrap_up;
  end
  // watchdog against a hung handshake
  initial begin
    tick(60000);
    fail_count++;
    wrap_up;
  end
endmodule
`default_nettype wire
